// ===== src/dbgeac_pkg.sv
// package: register map, field positions and codes for the debug event action control block
`default_nettype none
package dbgeac_pkg;
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_EXT_SPEC = 8'h08;
  localparam logic [7:0] OFF_RES_SPEC = 8'h0c;
  localparam logic [7:0] OFF_SW_SPEC  = 8'h10;
  localparam logic [7:0] OFF_TR0_SPEC = 8'h20;
  localparam logic [7:0] OFF_TR1_SPEC = 8'h24;
  localparam logic [7:0] OFF_SRV_CTRL = 8'hbc;

  localparam int ST_DE     = 0;
  localparam int ST_HALT   = 1;
  localparam int ST_HMASK  = 2;
  localparam int ST_SUSPEND_STATE   = 4;
  localparam int ST_PSUSP  = 6;
  localparam int ST_POSTED_EVENT   = 7;
  localparam int ST_ORG_LO = 8;

  localparam int SP_BBM  = 3;
  localparam int SP_SUSPEND_STATE = 5;
  localparam int SP_CMB  = 8;

  localparam int SR_TOS  = 10;
  localparam int SR_SRE  = 12;
  localparam int SR_SRR  = 13;
  localparam int SR_CLR  = 14;
  localparam int SR_SET  = 15;

  localparam logic [31:0] SPEC_MASK  = 32'h0000_002f;
  localparam logic [31:0] TRIG_MASK  = 32'h0000_0f2f;
  localparam logic [31:0] SRV_MASK   = 32'h0000_1cff;
  localparam logic [31:0] SPEC_RESET = 32'h0000_0000;
  localparam logic [31:0] SRV_RESET  = 32'h0000_0000;

  localparam logic [4:0] ORG_EXT = 5'h00;
  localparam logic [4:0] ORG_RES = 5'h01;
  localparam logic [4:0] ORG_SW  = 5'h02;
  localparam logic [4:0] ORG_TR0 = 5'h10;

  localparam logic [2:0] ACT_NONE  = 3'h0;
  localparam logic [2:0] ACT_PULSE = 3'h1;
  localparam logic [2:0] ACT_HALT  = 3'h2;
  localparam logic [2:0] ACT_TRAP  = 3'h3;
  localparam logic [2:0] ACT_SWBRK = 3'h4;

  typedef enum logic [1:0] {DBGEAC_IDLE, DBGEAC_DATA} dbgeac_bus_t;
endpackage : dbgeac_pkg
`default_nettype wire

// ===== src/dbgeac_top.sv
// debug event action control: status word, event specifiers, software break service request
//
// Contract
// RL1 - status bit 0 shows debug enabled at reset
// RL2 - halt bits 2:1, upper masks, reads zero
// RL3 - write 10 clears, 11 sets if enabled
// RL4 - halt field reads 00 running, 01 halted
// RL5 - bit 4 is suspend level, writable
// RL6 - bit 6 holds previous suspend level
// RL7 - bit 7 posted event, writable, hardware set
// RL8 - bits 12:8 record last event source
// RL9 - three-bit action code selects response
// RL10 - codes 101 to 111 act as none
// RL11 - bit 3 selects break before commit
// RL12 - bit 5 value driven onto suspend
// RL13 - trigger events with data always break after
// RL14 - trigger bits 8 to 11 combine enables
// RL15 - service priority in bits 7:0
// RL16 - service target in bits 11:10
// RL17 - bit 12 enables service request
// RL18 - bit 13 pending flag, read only
// RL19 - bit 14 clears pending unless set too
// RL20 - bit 15 sets pending, reads zero
// RL21 - no events unless debug enabled
// RL22 - halt or trap updates origin, pulses break-out
// RL23 - debugger resumes halted core with 10
// RL24 - software breakpoint action sets pending flag
// RL25 - reserved bits read zero, ignore writes
`default_nettype none
module dbgeac_top
  import dbgeac_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // debug strap and event sources
  input  wire logic        debug_strap,
  input  wire logic        break_in_pin_n,
  input  wire logic        resource_access,
  input  wire logic        debug_instr,
  input  wire logic [1:0]  trigger_fire,
  input  wire logic [1:0]  trigger_has_data,
  // core side
  output logic             break_out_pin_n,
  output logic             halted,
  output logic             trap_req,
  output logic             stop_before_commit,
  output logic             suspend_out,
  output logic             service_req,
  output logic [7:0]       service_priority,
  output logic [1:0]       service_target,
  output logic [7:0]       combine_enables
);

  logic        debug_enabled_q, strap_taken_q;
  logic        halt_q, suspend_state_q, prior_suspend_state_q, posted_q, pending_q;
  logic [4:0]  origin_q;
  logic [31:0] spec_q [5];
  logic [31:0] srv_q;
  logic        wr_pend_q, rd_pend_q;
  logic [7:0]  addr_q;
  logic [2:0]  brk_sync_q;
  logic        brk_seen_q;
  logic        brk_pulse_q, trap_q, sbc_q, spend_q;

  // reserved codes behave as none
  function automatic logic [2:0] act_of(input logic [31:0] spec);
    act_of = (spec[2:0] > ACT_SWBRK) ? ACT_NONE : spec[2:0];  // see RL10
  endfunction : act_of

  // strap caught after reset release
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      debug_enabled_q <= 1'b0;
      strap_taken_q   <= 1'b0;
    end else if (!strap_taken_q) begin
      debug_enabled_q <= debug_strap;  // see RL1
      strap_taken_q   <= 1'b1;
    end
  end

  // bus address phase capture
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  wire wr_st  = wr_pend_q && (addr_q == OFF_STATUS);
  wire wr_srv = wr_pend_q && (addr_q == OFF_SRV_CTRL);

  // break-in pin: three-stage sync, active low, falling edge once stages agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      brk_sync_q <= 3'b111;
      brk_seen_q <= 1'b0;
    end else begin
      brk_sync_q <= {brk_sync_q[1:0], break_in_pin_n};
      if (brk_sync_q[1] == brk_sync_q[2]) begin
        brk_seen_q <= !brk_sync_q[2];
      end
    end
  end
  wire brk_fall = (brk_sync_q[1] == brk_sync_q[2]) && !brk_sync_q[2] && !brk_seen_q;

  // event selection, fixed priority ext, resource, sw, trigger 0, trigger 1
  logic       ev_fire;
  logic [2:0] ev_idx;
  logic [4:0] ev_org;
  always_comb begin
    ev_fire = debug_enabled_q;  // see RL21
    ev_idx  = 3'd0;
    ev_org  = ORG_EXT;
    if (brk_fall) begin
      ev_idx = 3'd0;
      ev_org = ORG_EXT;
    end else if (resource_access) begin
      ev_idx = 3'd1;
      ev_org = ORG_RES;
    end else if (debug_instr) begin
      ev_idx = 3'd2;
      ev_org = ORG_SW;
    end else if (trigger_fire[0]) begin
      ev_idx = 3'd3;
      ev_org = ORG_TR0;  // see RL8
    end else if (trigger_fire[1]) begin
      ev_idx = 3'd4;
      ev_org = ORG_TR0 + 5'd1;
    end else begin
      ev_fire = 1'b0;
    end
  end
  wire [2:0] ev_act = ev_fire ? act_of(spec_q[ev_idx]) : ACT_NONE;  // see RL9
  wire       ev_bbm = spec_q[ev_idx][SP_BBM] &&
                      !(ev_idx >= 3'd3 && trigger_has_data[ev_idx[0] ? 0 : 1]);  // see RL13
  wire       ev_brk = (ev_act == ACT_HALT) || (ev_act == ACT_TRAP);

  // event specifier registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 5; i++) begin
        spec_q[i] <= SPEC_RESET;
      end
    end else if (wr_pend_q) begin
      case (addr_q)
        OFF_EXT_SPEC: spec_q[0] <= hwdata & SPEC_MASK;  // see RL25
        OFF_RES_SPEC: spec_q[1] <= hwdata & SPEC_MASK;
        OFF_SW_SPEC:  spec_q[2] <= hwdata & SPEC_MASK;
        OFF_TR0_SPEC: spec_q[3] <= hwdata & TRIG_MASK;  // see RL14
        OFF_TR1_SPEC: spec_q[4] <= hwdata & TRIG_MASK;
        default: ;
      endcase
    end
  end

  // halt bit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      halt_q <= 1'b0;
    end else if (ev_act == ACT_HALT) begin
      halt_q <= 1'b1;
    end else if (wr_st && hwdata[ST_HMASK]) begin  // see RL2
      if (!hwdata[ST_HALT]) begin
        halt_q <= 1'b0;  // see RL3
      end else if (debug_enabled_q) begin
        halt_q <= 1'b1;  // see RL3
      end
    end
  end

  // suspend level and its previous value
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      suspend_state_q       <= 1'b0;
      prior_suspend_state_q <= 1'b0;
    end else if (ev_act != ACT_NONE) begin
      suspend_state_q       <= spec_q[ev_idx][SP_SUSPEND_STATE];  // see RL12
      prior_suspend_state_q <= suspend_state_q;  // see RL6
    end else if (wr_st) begin
      suspend_state_q       <= hwdata[ST_SUSPEND_STATE];  // see RL5
      prior_suspend_state_q <= suspend_state_q;
    end
  end

  // posted event flag and origin; hardware set wins over a software write
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      posted_q <= 1'b0;
      origin_q <= 5'h00;
    end else begin
      if (ev_act != ACT_NONE) begin
        posted_q <= 1'b1;  // see RL7
      end else if (wr_st) begin
        posted_q <= hwdata[ST_POSTED_EVENT];
      end
      if (ev_act != ACT_NONE) begin
        origin_q <= ev_org;  // see RL22
      end
    end
  end

  // service request control and pending flag; set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      srv_q     <= SRV_RESET;
      pending_q <= 1'b0;
    end else begin
      if (wr_srv) begin
        srv_q <= hwdata & SRV_MASK;  // see RL15
      end
      if (ev_act == ACT_SWBRK || (wr_srv && hwdata[SR_SET])) begin  // see RL24
        pending_q <= 1'b1;  // see RL20
      end else if (wr_srv && hwdata[SR_CLR]) begin
        pending_q <= 1'b0;  // see RL19
      end
    end
  end

  // core-side event outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      brk_pulse_q <= 1'b0;
      trap_q      <= 1'b0;
      sbc_q       <= 1'b0;
      spend_q     <= 1'b0;
    end else begin
      brk_pulse_q <= (ev_act == ACT_PULSE) || ev_brk;  // see RL22
      trap_q      <= ev_act == ACT_TRAP;
      if (ev_brk) begin
        sbc_q <= ev_bbm;  // see RL11
      end
      spend_q <= pending_q && srv_q[SR_SRE] && (srv_q[7:0] != 8'h00);  // see RL17
    end
  end

  // read mux, data phase register
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (addr_q)
      OFF_STATUS: begin
        rd_d[ST_DE]               = debug_enabled_q;
        rd_d[ST_HALT]             = halt_q;  // see RL4
        rd_d[ST_SUSPEND_STATE]             = suspend_state_q;
        rd_d[ST_PSUSP]            = prior_suspend_state_q;
        rd_d[ST_POSTED_EVENT]             = posted_q;
        rd_d[ST_ORG_LO +: 5]      = origin_q;
      end
      OFF_EXT_SPEC: rd_d = spec_q[0];
      OFF_RES_SPEC: rd_d = spec_q[1];
      OFF_SW_SPEC:  rd_d = spec_q[2];
      OFF_TR0_SPEC: rd_d = spec_q[3];
      OFF_TR1_SPEC: rd_d = spec_q[4];
      OFF_SRV_CTRL: begin
        rd_d         = srv_q;
        rd_d[SR_SRR] = pending_q;  // see RL18
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata <= rd_d;
    end
  end

  // one wait state on reads so hrdata leaves a flop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(take && !hwrite);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hresp              <= 1'b0;
      break_out_pin_n    <= 1'b1;
      halted             <= 1'b0;
      trap_req           <= 1'b0;
      stop_before_commit <= 1'b0;
      suspend_out        <= 1'b0;
      service_req        <= 1'b0;
      service_priority   <= 8'h00;
      service_target     <= 2'b00;
      combine_enables    <= 8'h00;
    end else begin
      hresp              <= 1'b0;
      break_out_pin_n    <= !brk_pulse_q;
      halted             <= halt_q;
      trap_req           <= trap_q;
      stop_before_commit <= sbc_q;
      suspend_out        <= suspend_state_q;
      service_req        <= spend_q;
      service_priority   <= srv_q[7:0];
      service_target     <= srv_q[SR_TOS +: 2];  // see RL16
      combine_enables    <= {spec_q[4][SP_CMB +: 4], spec_q[3][SP_CMB +: 4]};
    end
  end

  // assertions
  a_halt_needs_enable: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL3
    $rose(halt_q) |-> debug_enabled_q) else $error("halt set while debug disabled");
  a_halt_clear_code: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL3
    (wr_st && hwdata[2:1] == 2'b10 && ev_act != ACT_HALT) |=> !halt_q)
    else $error("halt not cleared by code 10");
  a_halt_no_mask: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL2
    (wr_st && !hwdata[ST_HMASK] && ev_act != ACT_HALT) |=> $stable(halt_q))
    else $error("halt changed without mask");
  a_no_evt_disabled: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL21
    (!debug_enabled_q && !wr_st) |=> $stable(posted_q) && $stable(origin_q) && !trap_q)
    else $error("event while disabled");
  a_strap_held: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL1
    strap_taken_q |=> $stable(debug_enabled_q))
    else $error("debug enable changed after capture");
  a_reserved_code: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL10
    (ev_fire && spec_q[ev_idx][2:0] > 3'd4) |-> ev_act == ACT_NONE)
    else $error("reserved action acted");
  a_origin_hold: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL10
    ev_act == ACT_NONE |=> $stable(origin_q)) else $error("origin moved without action");
  a_brk_out_pulse: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL22
    ev_brk |-> ##2 !break_out_pin_n) else $error("break-out missing");
  a_origin_update: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL22
    ev_brk |=> origin_q == $past(ev_org)) else $error("origin not updated");
  a_set_wins: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL20
    (wr_srv && hwdata[SR_SET]) |=> pending_q) else $error("pending not set");
  a_clear_pend: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL19
    (wr_srv && hwdata[SR_CLR] && !hwdata[SR_SET] && ev_act != ACT_SWBRK) |=> !pending_q)
    else $error("pending not cleared");
  a_swbrk_pend: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL24
    ev_act == ACT_SWBRK |=> pending_q) else $error("sw break did not pend");
  a_data_after: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL13
    (ev_brk && ev_idx >= 3'd3 && trigger_has_data[ev_idx == 3'd3 ? 0 : 1]) |=> !sbc_q)
    else $error("data trigger broke before commit");
  a_suspend_state_value: assert property (@(posedge mclk) disable iff (!reset_n)  // see RL12
    ev_act != ACT_NONE |=> suspend_state_q == $past(spec_q[ev_idx][SP_SUSPEND_STATE]))
    else $error("suspend value wrong");

  // covers for the main scenarios
  c_halt_evt: cover property (@(posedge mclk) disable iff (!reset_n) ev_act == ACT_HALT);
  c_pin_evt:  cover property (@(posedge mclk) disable iff (!reset_n) brk_fall && debug_enabled_q);
  c_trap_evt: cover property (@(posedge mclk) disable iff (!reset_n) ev_act == ACT_TRAP);
  c_srv_req:  cover property (@(posedge mclk) disable iff (!reset_n) $rose(service_req));
  c_resume:   cover property (@(posedge mclk) disable iff (!reset_n) $fell(halt_q));

endmodule : dbgeac_top
`default_nettype wire

// ===== tb/dbgeac_core_model.sv
// core-side model: raises the event sources toward the debug block
`default_nettype none
module dbgeac_core_model (
  // clock
  input  wire logic       mclk,
  // event sources
  output var  logic       break_in_pin_n,
  output var  logic       resource_access,
  output var  logic       debug_instr,
  output var  logic [1:0] trigger_fire,
  output var  logic [1:0] trigger_has_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    break_in_pin_n = 1'b1;
    resource_access = 1'b0;
    debug_instr = 1'b0;
    trigger_fire = 2'b00;
    trigger_has_data = 2'b00;
  end

  // source 0 pin, 1 resource, 2 debug instruction, 3 and 4 trigger combiners
  task automatic fire(input int s, input logic dat);
    trigger_has_data <= {dat, dat};
    case (s)
      0: break_in_pin_n <= 1'b0;
      1: resource_access <= 1'b1;
      2: debug_instr <= 1'b1;
      default: trigger_fire[s-3] <= 1'b1;
    endcase
    // the pin is slow and asynchronous, held long enough for the synchroniser
    repeat (s == 0 ? 4 : 1) @(posedge mclk);
    break_in_pin_n <= 1'b1;
    resource_access <= 1'b0;
    debug_instr <= 1'b0;
    trigger_fire <= 2'b00;
  endtask : fire
endmodule : dbgeac_core_model
`default_nettype wire

// ===== tb/dbgeac_bench.sv
// self-checking bench for the debug event action control block
`default_nettype none
module dbgeac_bench
  import dbgeac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b1;
  logic        hwrite = 1'b0;
  logic        debug_strap = 1'b1;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, break_out_pin_n, halted, trap_req, stop_before_commit;
  logic        suspend_out, service_req, break_in_pin_n, resource_access, debug_instr;
  logic [1:0]  service_target, trigger_fire, trigger_has_data;
  logic [7:0]  service_priority, combine_enables;
  int          fails = 0, samples_checked = 0, cycles = 0;

  always #20 mclk = ~mclk;

  dbgeac_top dut (
    .mclk               (mclk),
    .reset_n            (reset_n),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (3'h2),
    .hwdata             (hwdata),
    .hready             (hreadyout),
    .hrdata             (hrdata),
    .hreadyout          (hreadyout),
    .hresp              (hresp),
    .debug_strap        (debug_strap),
    .break_in_pin_n     (break_in_pin_n),
    .resource_access    (resource_access),
    .debug_instr        (debug_instr),
    .trigger_fire       (trigger_fire),
    .trigger_has_data   (trigger_has_data),
    .break_out_pin_n    (break_out_pin_n),
    .halted             (halted),
    .trap_req           (trap_req),
    .stop_before_commit (stop_before_commit),
    .suspend_out        (suspend_out),
    .service_req        (service_req),
    .service_priority   (service_priority),
    .service_target     (service_target),
    .combine_enables    (combine_enables)
  );
  dbgeac_core_model core (.mclk, .break_in_pin_n, .resource_access, .debug_instr,
                          .trigger_fire, .trigger_has_data);

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // fire one source, then count break-out cycles and note whether a trap request was seen
  task automatic raise(input int s, input logic dat, output int bo, output logic tr);
    bo = 0;
    tr = 1'b0;
    core.fire(s, dat);
    repeat (10) begin
      @(posedge mclk);
      bo += int'(break_out_pin_n === 1'b0);
      tr |= (trap_req === 1'b1);
    end
  endtask : raise

  task automatic t_reset_map();
    logic [7:0] offs [5] = '{OFF_EXT_SPEC, OFF_RES_SPEC, OFF_SW_SPEC, OFF_TR0_SPEC, OFF_TR1_SPEC};
    bus(0, OFF_STATUS, 0);
    check("status", rd, 32'h0000_0001);
    bus(0, OFF_SRV_CTRL, 0);
    check("service ctrl", rd, 32'h0000_0000);
    foreach (offs[i]) begin
      bus(0, offs[i], 0);
      check("spec reset", rd, 32'h0000_0000);
      bus(1, offs[i], 32'hffff_ffff);
      bus(0, offs[i], 0);
      check("spec mask", rd, i > 2 ? 32'h0000_0f2f : 32'h0000_002f);
      bus(1, offs[i], 0);
    end
    bus(1, 8'h40, 32'hffff_ffff);
    bus(0, 8'h40, 0);
    check("unmapped", rd, 32'h0000_0000);
    check("response", hresp, 1'b0);
  endtask : t_reset_map

  task automatic t_halt_field();
    logic [2:0] wr [5] = '{3'h2, 3'h6, 3'h2, 3'h0, 3'h4};
    logic [2:0] ex [5] = '{3'h1, 3'h3, 3'h3, 3'h3, 3'h1};
    foreach (wr[i]) begin
      // the last write resumes the halted core
      bus(1, OFF_STATUS, {29'h0, wr[i]});
      bus(0, OFF_STATUS, 0);
      check("halt field", rd[2:0], ex[i]);
      check("halted", halted, ex[i][1]);
    end
  endtask : t_halt_field

  task automatic t_actions();
    int bo;
    logic tr;
    logic [4:0] org = 5'h00;
    for (int c = 7; c >= 0; c--) begin
      bus(1, OFF_SW_SPEC, 32'(c));
      raise(2, 1'b0, bo, tr);
      if (c inside {[1:4]}) org = 5'h02;
      check("break-out", bo, (c inside {[1:3]}) ? 1 : 0);
      check("trap", tr, c == 3);
      check("halted", halted, c == 2);
      bus(0, OFF_STATUS, 0);
      check("status", rd & 32'hffff_ff7f, {org, 6'h0, c == 2, 1'b1});
      bus(0, OFF_SRV_CTRL, 0);
      check("pending", rd[13], c == 4);
      bus(1, OFF_STATUS, 32'h0000_0004);
      bus(1, OFF_SRV_CTRL, 32'h0000_4000);
    end
  endtask : t_actions

  task automatic t_origins();
    logic [7:0] offs [5] = '{OFF_EXT_SPEC, OFF_RES_SPEC, OFF_SW_SPEC, OFF_TR0_SPEC, OFF_TR1_SPEC};
    logic [4:0] org [5] = '{5'h00, 5'h01, 5'h02, 5'h10, 5'h11};
    logic prior = 1'b0;
    logic suspend_state;
    int bo;
    logic tr;
    foreach (offs[i]) begin
      suspend_state = (i % 2 == 0);
      bus(1, offs[i], {26'h0, suspend_state, 5'h01});
      raise(i, 1'b0, bo, tr);
      check("break-out", bo, 1);
      bus(0, OFF_STATUS, 0);
      check("status", rd & 32'h0000_1fd0, {org[i], 1'b1, prior, 1'b0, suspend_state, 4'h0});
      check("suspend", suspend_out, suspend_state);
      prior = suspend_state;
      bus(1, offs[i], 0);
    end
    bus(1, OFF_STATUS, 32'h0000_0010);
    bus(0, OFF_STATUS, 0);
    check("status write", rd & 32'h0000_00d0, {1'b0, prior, 2'b01, 4'h0});
    bus(1, OFF_STATUS, 0);
  endtask : t_origins

  task automatic t_triggers();
    int bo;
    logic tr;
    bus(1, OFF_TR0_SPEC, 32'hffff_ffdb);
    bus(1, OFF_TR1_SPEC, 32'h0000_050b);
    bus(0, OFF_TR0_SPEC, 0);
    check("trigger spec", rd, 32'h0000_0f0b);
    check("combine", combine_enables, 8'h5f);
    raise(3, 1'b0, bo, tr);
    check("trap", tr, 1'b1);
    check("before commit", stop_before_commit, 1'b1);
    raise(4, 1'b1, bo, tr);
    check("before commit", stop_before_commit, 1'b0);
    bus(1, OFF_TR0_SPEC, 0);
    bus(1, OFF_TR1_SPEC, 0);
  endtask : t_triggers

  task automatic t_service();
    logic [31:0] wr [4] = '{32'h0000_b5a5, 32'h0000_d4a5, 32'h0000_54a5, 32'h0000_9400};
    logic [31:0] ex [4] = '{32'h0000_34a5, 32'h0000_34a5, 32'h0000_14a5, 32'h0000_3400};
    logic rq [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    foreach (wr[i]) begin
      bus(1, OFF_SRV_CTRL, wr[i]);
      bus(0, OFF_SRV_CTRL, 0);
      check("service ctrl", rd, ex[i]);
      check("service request", service_req, rq[i]);
      check("routing", {service_target, service_priority}, {ex[i][11:10], ex[i][7:0]});
    end
    bus(1, OFF_SRV_CTRL, 32'h0000_4000);
  endtask : t_service

  task automatic t_disabled();
    int bo;
    logic tr;
    debug_strap <= 1'b0;
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    bus(1, OFF_SW_SPEC, 32'h0000_0002);
    raise(2, 1'b0, bo, tr);
    check("break-out", bo, 0);
    check("halted", halted, 1'b0);
    bus(1, OFF_STATUS, 32'h0000_0006);
    bus(0, OFF_STATUS, 0);
    check("status", rd, 32'h0000_0000);
  endtask : t_disabled

  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset_map();
    t_halt_field();
    t_actions();
    t_origins();
    t_triggers();
    t_service();
    t_disabled();
    final_report();
  end
endmodule : dbgeac_bench
`default_nettype wire
